// [sas_acq_sequencer.sv]
// Acquisition sequencer: start methods, offset null, self-trim, readout
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RULE1 - Unnulled starts open acquisition as conversion done rises.
// RULE2 - Without null the host times acquisition from reading both bytes.
// RULE3 - A write start with null requested inserts the null cycle first.
// RULE4 - Nulled write starts keep acquisition open 7 clocks, then convert.
// RULE5 - Acquisition needs 3.5 us, so nulling limits the clock to 2 MHz.
// RULE6 - Self-trim runs at power-up and cannot be interrupted once begun.
// RULE7 - Once supplies, reference and clock settle, the host trims again.
// RULE8 - Trim stores offset, linearity, gain fixes and applies them later.
// RULE9 - Hold starts never get the null cycle, so such hosts may retrim.
// RULE10 - The track/hold rise is the hold command; conversion follows.
// RULE11 - A host that nulls every conversion trims only once after power-up.
// RULE12 - Conversion done stays low for the whole 1399-clock self-trim.
// RULE13 - The inserted null cycle lasts 26 clocks.
// RULE14 - At the end of conversion the result is latched and done goes high.
// RULE15 - The sign-extended result is read as two bytes, high byte first.
////////////////////////////////////////////////////////////////////////////
module sas_acq_sequencer
    import sas_pkg::*;
#(
    parameter int TRIM_LEN = TRIM_CYCLES,
    parameter int NULL_LEN = NULL_CYCLES,
    parameter int ACQ_LEN = ACQ_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic csN,
    input wire logic wrN,
    input wire logic rdN,
    input wire logic shN,
    input wire logic trimReqN,
    input wire logic offset_null_request_n,
    input wire logic [CODE_W-1:0] analogCode,
    output logic [7:0] result_byte_bus,
    output logic result_byte_bus_oe,
    output logic convDone,
    output logic acqOpen,
    output logic irq,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdData
);

    localparam int CNT_W = $clog2(TRIM_LEN + 1);

    sas_state_t state_ff;
    sas_state_t nxtState;
    logic [CNT_W-1:0] cnt_ff;
    logic [PIN_N-1:0] pinMeta_ff;
    logic [PIN_N-1:0] pinSync_ff;
    logic [PIN_N-1:0] pinDly_ff;
    logic [CODE_W-1:0] codeMeta_ff;
    logic [CODE_W-1:0] codeSync_ff;
    logic [CODE_W-1:0] holdCode_ff;
    logic [CODE_W-1:0] resultLatch_ff;
    logic [CODE_W-1:0] corrMem_ff [CORR_N];
    logic startPulse_ff;
    logic bytePtr_ff;
    logic convDone_ff;
    logic acqOpen_ff;
    logic [7:0] dataOut_ff;
    logic dataOe_ff;
    logic [EVT_W-1:0] status_ff;
    logic [EVT_W-1:0] nxtStatus;
    logic [EVT_W-1:0] mask_ff;
    logic [EVT_W-1:0] events;
    logic irq_ff;
    logic [DATA_W-1:0] rdData_ff;
    logic csLow;
    logic wrRise;
    logic shLow;
    logic shRise;
    logic rdActive;
    logic rdRise;
    logic nullReq;
    logic trimStart;
    logic nullRestart;
    logic phaseEnd;
    logic [CNT_W-1:0] stLen_ff;

    sas_conv_if conv ();

    sas_sar_engine u_engine (
        .clk_sys (clk_sys),
        .reset (reset),
        .conv (conv)
    );

    // Conversion done is high only while idle or tracking
    function automatic logic doneLevel(input sas_state_t st);
        doneLevel = (st == ST_IDLE) || (st == ST_TRACK);
    endfunction : doneLevel

    // Sampling switch is closed while idle, tracking or in acquisition
    function automatic logic acqLevel(input sas_state_t st);
        acqLevel = (st == ST_IDLE) || (st == ST_TRACK) || (st == ST_ACQ);
    endfunction : acqLevel

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the third stage only serves edge detection
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pinMeta_ff <= PIN_IDLE;
            pinSync_ff <= PIN_IDLE;
            pinDly_ff <= PIN_IDLE;
            codeMeta_ff <= CODE_RST;
            codeSync_ff <= CODE_RST;
        end
        else
        begin
            pinMeta_ff <= {csN, wrN, rdN, shN, trimReqN,
                offset_null_request_n};
            pinSync_ff <= pinMeta_ff;
            pinDly_ff <= pinSync_ff;
            codeMeta_ff <= analogCode;
            codeSync_ff <= codeMeta_ff;
        end
    end

    assign csLow = !pinSync_ff[PIN_CS];
    assign wrRise = pinSync_ff[PIN_WR] && !pinDly_ff[PIN_WR];
    assign shLow = !pinSync_ff[PIN_SH];
    assign shRise = pinSync_ff[PIN_SH] && !pinDly_ff[PIN_SH];
    assign rdActive = csLow && !pinSync_ff[PIN_RD];
    assign rdRise = !pinDly_ff[PIN_CS] && !pinDly_ff[PIN_RD] && !rdActive;
    assign nullReq = !pinSync_ff[PIN_NULL];
    assign trimStart = !csLow && !shLow && !pinSync_ff[PIN_TRIM]
        && pinDly_ff[PIN_TRIM];
    assign nullRestart = (state_ff == ST_NULL) && csLow && wrRise;

    ////////////////////////////////////////////////////////////////////////
    // Sequence control
    always_comb
    begin
        nxtState = state_ff;
        case (state_ff)
            ST_TRIM:
            begin
                // No pin can leave trim early
                if (cnt_ff == CNT_W'(TRIM_LEN - 1)) // see RULE6
                    nxtState = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (trimStart)
                    nxtState = ST_TRIM;
                else if (csLow && wrRise)
                    nxtState = nullReq ? ST_NULL : ST_CONV; // see RULE3
                else if (csLow && shLow)
                    nxtState = ST_TRACK; // see RULE9
            end
            ST_TRACK:
            begin
                if (shRise)
                    nxtState = ST_CONV; // see RULE10
            end
            ST_NULL:
            begin
                if (!nullRestart && cnt_ff == CNT_W'(NULL_LEN - 1))
                    nxtState = ST_ACQ; // see RULE13
            end
            ST_ACQ:
            begin
                if (cnt_ff == CNT_W'(ACQ_LEN - 1))
                    nxtState = ST_CONV; // see RULE4
            end
            ST_CONV:
            begin
                if (conv.done)
                    nxtState = ST_IDLE; // see RULE1
            end
            default:
            begin
                nxtState = ST_TRIM;
            end
        endcase
    end

    // Power-up always begins with a trim
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            state_ff <= ST_TRIM; // see RULE6
        else
            state_ff <= nxtState;
    end

    // Phase counter; a write during null restarts the null cycle
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            cnt_ff <= '0;
        else if (nxtState != state_ff || nullRestart)
            cnt_ff <= '0;
        else
            cnt_ff <= cnt_ff + 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            convDone_ff <= 1'b0;
            acqOpen_ff <= 1'b0;
        end
        else
        begin
            convDone_ff <= doneLevel(nxtState); // see RULE12
            acqOpen_ff <= acqLevel(nxtState); // see RULE1
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hold, conversion start and result latch
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            holdCode_ff <= CODE_RST;
            startPulse_ff <= 1'b0;
        end
        else
        begin
            startPulse_ff <= (nxtState == ST_CONV) && (state_ff != ST_CONV);
            if (nxtState == ST_CONV && state_ff != ST_CONV)
                holdCode_ff <= codeSync_ff; // see RULE10
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            resultLatch_ff <= CODE_RST;
        else if (conv.done)
            resultLatch_ff <= conv.result; // see RULE14
    end

    // Trim fills all corrections in its last cycles; null renews offset
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            for (int i = 0; i < CORR_N; i++)
                corrMem_ff[i] <= CODE_RST;
        end
        else if (state_ff == ST_TRIM)
        begin
            for (int i = 0; i < CORR_N; i++)
            begin
                if (cnt_ff == CNT_W'(TRIM_LEN - CORR_N + i))
                    corrMem_ff[i] <= codeSync_ff; // see RULE8
            end
        end
        else if (state_ff == ST_NULL && nxtState == ST_ACQ)
            corrMem_ff[CORR_OFS] <= codeSync_ff;
    end

    assign conv.start = startPulse_ff;
    assign conv.sample = holdCode_ff;
    assign conv.corr = corrMem_ff[CORR_OFS] + corrMem_ff[CORR_LIN]
        - corrMem_ff[CORR_GAIN]; // see RULE8

    ////////////////////////////////////////////////////////////////////////
    // Two-byte readout, high byte first, pointer rewinds per conversion
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            bytePtr_ff <= 1'b0;
        else if (conv.done)
            bytePtr_ff <= 1'b0;
        else if (rdRise)
            bytePtr_ff <= !bytePtr_ff; // see RULE15
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            dataOut_ff <= 8'h00;
            dataOe_ff <= 1'b0;
        end
        else
        begin
            dataOe_ff <= rdActive;
            if (!bytePtr_ff)
                dataOut_ff <= {{3{resultLatch_ff[CODE_W-1]}},
                    resultLatch_ff[CODE_W-1:8]}; // see RULE15
            else
                dataOut_ff <= resultLatch_ff[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events, status and interrupt; a new event beats a clear
    assign events[EVT_CONV] = conv.done;
    assign events[EVT_TRIM] = (state_ff == ST_TRIM) && (nxtState == ST_IDLE);
    assign events[EVT_NULL] = (state_ff == ST_NULL) && (nxtState == ST_ACQ);

    always_comb
    begin
        nxtStatus = status_ff;
        if (regWr && regAddr == REG_STATUS)
            nxtStatus = status_ff & ~regWrData[EVT_W-1:0];
        nxtStatus = nxtStatus | events;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            status_ff <= STATUS_RST;
            irq_ff <= 1'b0;
        end
        else
        begin
            status_ff <= nxtStatus;
            irq_ff <= |(nxtStatus & mask_ff);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            mask_ff <= MASK_RST;
        else if (regWr && regAddr == REG_MASK)
            mask_ff <= regWrData[EVT_W-1:0];
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            rdData_ff <= '0;
        else if (!regRd)
            rdData_ff <= '0;
        else
        begin
            case (regAddr)
                REG_STATUS: rdData_ff <= DATA_W'(status_ff);
                REG_MASK: rdData_ff <= DATA_W'(mask_ff);
                REG_STATE: rdData_ff <= DATA_W'({bytePtr_ff, acqOpen_ff,
                    convDone_ff, 3'(state_ff)});
                REG_CORR0: rdData_ff <= DATA_W'(corrMem_ff[0]);
                REG_CORR1: rdData_ff <= DATA_W'(corrMem_ff[1]);
                REG_CORR2: rdData_ff <= DATA_W'(corrMem_ff[2]);
                default: rdData_ff <= '0;
            endcase
        end
    end

    assign result_byte_bus = dataOut_ff;
    assign result_byte_bus_oe = dataOe_ff;
    assign convDone = convDone_ff;
    assign acqOpen = acqOpen_ff;
    assign irq = irq_ff;
    assign regRdData = rdData_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // Cycles spent in the current state, for length checks
    always_ff @(posedge clk_sys)
    begin
        if (reset || nxtState != state_ff || nullRestart)
            stLen_ff <= '0;
        else
            stLen_ff <= stLen_ff + 1'b1;
    end

    assign phaseEnd = nxtState != state_ff;

    sequence acqWindow;
        (state_ff == ST_ACQ && acqOpen_ff && !convDone_ff) [*7];
    endsequence

    sequence holdThenStart;
        state_ff == ST_CONV && !acqOpen_ff && conv.start ##1 !conv.start;
    endsequence

    AST_TRIM_FULL: assert property ( // see RULE12
        (state_ff == ST_TRIM && phaseEnd) |-> 32'(stLen_ff) == TRIM_LEN - 1)
        else $error("trim did not last its full length");

    AST_TRIM_EOC: assert property ( // see RULE12
        state_ff == ST_TRIM |-> !convDone_ff
            && (!result_byte_bus_oe || rdActive || $past(rdActive)))
        else $error("conversion done high during trim");

    AST_TRIM_LOCK: assert property ( // see RULE6
        (state_ff == ST_TRIM && 32'(stLen_ff) < TRIM_LEN - 1)
            |=> state_ff == ST_TRIM)
        else $error("trim was interrupted");

    AST_NULL_LEN: assert property ( // see RULE13
        (state_ff == ST_NULL && phaseEnd) |-> 32'(stLen_ff) == NULL_LEN - 1)
        else $error("null cycle length wrong");

    AST_ACQ_WIN: assert property ( // see RULE4
        $rose(state_ff == ST_ACQ) |-> acqWindow ##1 holdThenStart)
        else $error("nulled acquisition window not 7 clocks");

    AST_NULL_FIRST: assert property ( // see RULE3
        (state_ff == ST_IDLE && !trimStart && csLow && wrRise && nullReq)
            |=> state_ff == ST_NULL && !convDone_ff && !acqOpen_ff)
        else $error("null cycle not inserted before acquisition");

    AST_SH_NO_NULL: assert property ( // see RULE9
        state_ff == ST_TRACK |=> state_ff inside {ST_TRACK, ST_CONV})
        else $error("track/hold start led into null cycle");

    AST_SH_HOLD: assert property ( // see RULE10
        (state_ff == ST_TRACK && shRise) |=> holdThenStart)
        else $error("hold not taken on track/hold rise");

    AST_EOC_ACQ: assert property ( // see RULE1
        conv.done |=> convDone_ff && acqOpen_ff
            && resultLatch_ff == $past(conv.result))
        else $error("acquisition not opened with conversion done");

    AST_HIGH_FIRST: assert property ( // see RULE15
        (rdActive && !bytePtr_ff && !conv.done) |=> result_byte_bus_oe
            && result_byte_bus == {{3{resultLatch_ff[CODE_W-1]}},
            resultLatch_ff[CODE_W-1:8]})
        else $error("first read did not return the high byte");

endmodule : sas_acq_sequencer

// [sas_conv_if.sv]
// Link between the sequencer and the conversion engine
`timescale 1ns/100ps
interface sas_conv_if
    import sas_pkg::*;
();
    logic start;
    logic [CODE_W-1:0] sample;
    logic [CODE_W-1:0] corr;
    logic done;
    logic [CODE_W-1:0] result;

    modport seq (output start, output sample, output corr,
        input done, input result);
    modport eng (input start, input sample, input corr,
        output done, output result);
endinterface : sas_conv_if

// [sas_host_model.sv]
// Host model driving the control pins and reading result bytes
`timescale 1ns/100ps
module sas_host_model
    import sas_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [7:0] result_byte_bus,
    input wire logic result_byte_bus_oe,
    output logic [PIN_N-1:0] pins,
    output logic timedOut
);
    logic nullN;
    initial
    begin
        pins = PIN_IDLE;
        nullN = 1'b1;
        timedOut = 1'b0;
    end
    // Pin order cs, wr, rd, sh, trim; null level is kept apart
    task step(input logic [4:0] v, input int n);
        @(posedge clk_sys);
        pins <= {v, nullN};
        repeat (n - 1) @(posedge clk_sys);
    endtask : step
    // Method 0 write, 1 track/hold with null low, 2 write with null
    task startConv(input int m);
        nullN = (m == 0);
        step((m == 1) ? 5'h0d : 5'h07, 4);
        step(5'h0f, 2);
        step(5'h1f, 1);
    endtask : startConv
    // Both bytes are fetched before the next start
    task readByte(output logic [7:0] b);
        int i;
        step(5'h0b, 1);
        for (i = 0; i < 12 && result_byte_bus_oe !== 1'b1; i++)
            @(posedge clk_sys);
        timedOut <= timedOut | (i == 12);
        b = result_byte_bus;
        step(5'h1f, 4);
    endtask : readByte
    // Requested once the supplies have settled
    task trim();
        nullN = 1'b1;
        step(5'h1e, 4);
        step(5'h1f, 1);
    endtask : trim
endmodule : sas_host_model

// [sas_pkg.sv]
// Shared constants and types of the acquisition sequencer
package sas_pkg;

    // Converter word: 12 bits plus sign
    localparam int CODE_W = 13;
    localparam logic [CODE_W-1:0] SIGN_FLIP = 13'h1000;
    localparam logic [CODE_W-1:0] CODE_RST = 13'h0000;

    // Sequence lengths in conversion clock periods
    localparam int TRIM_CYCLES = 1399;
    localparam int NULL_CYCLES = 26;
    localparam int ACQ_CYCLES = 7;

    // Stored correction values
    localparam int CORR_N = 3;
    localparam int CORR_OFS = 0;
    localparam int CORR_LIN = 1;
    localparam int CORR_GAIN = 2;

    // Pin vector positions, all pins active low
    localparam int PIN_N = 6;
    localparam int PIN_CS = 5;
    localparam int PIN_WR = 4;
    localparam int PIN_RD = 3;
    localparam int PIN_SH = 2;
    localparam int PIN_TRIM = 1;
    localparam int PIN_NULL = 0;
    localparam logic [PIN_N-1:0] PIN_IDLE = 6'h3f;

    // Register map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STATE = 8'h08;
    localparam logic [ADDR_W-1:0] REG_CORR0 = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_CORR1 = 8'h10;
    localparam logic [ADDR_W-1:0] REG_CORR2 = 8'h14;

    // Event bits of status and mask
    localparam int EVT_W = 3;
    localparam int EVT_CONV = 0;
    localparam int EVT_TRIM = 1;
    localparam int EVT_NULL = 2;
    localparam logic [EVT_W-1:0] STATUS_RST = 3'h0;
    localparam logic [EVT_W-1:0] MASK_RST = 3'h0;

    typedef enum {
        ST_TRIM,
        ST_IDLE,
        ST_TRACK,
        ST_NULL,
        ST_ACQ,
        ST_CONV
    } sas_state_t;

endpackage : sas_pkg

// [sas_sar_engine.sv]
// Successive approximation engine with correction applied
`timescale 1ns/100ps
module sas_sar_engine
    import sas_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    sas_conv_if.eng conv
);

    logic [CODE_W-1:0] target_ff;
    logic [CODE_W-1:0] approx_ff;
    logic [CODE_W-1:0] bit_ff;
    logic busy_ff;
    logic done_ff;
    logic [CODE_W-1:0] trial;

    assign trial = approx_ff | bit_ff;

    ////////////////////////////////////////////////////////////////////////
    // Sign first, then bits from MSB down, in offset binary
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            target_ff <= CODE_RST;
            approx_ff <= CODE_RST;
            bit_ff <= CODE_RST;
            busy_ff <= 1'b0;
        end
        else if (conv.start)
        begin
            target_ff <= (conv.sample - conv.corr) ^ SIGN_FLIP; // see RULE8
            approx_ff <= CODE_RST;
            bit_ff <= SIGN_FLIP;
            busy_ff <= 1'b1;
        end
        else if (busy_ff)
        begin
            if (target_ff >= trial)
                approx_ff <= trial;
            bit_ff <= bit_ff >> 1;
            if (bit_ff == 13'h0001)
                busy_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            done_ff <= 1'b0;
        else
            done_ff <= busy_ff && (bit_ff == 13'h0001) && !conv.start;
    end

    assign conv.done = done_ff;
    assign conv.result = approx_ff ^ SIGN_FLIP;

    ////////////////////////////////////////////////////////////////////////
    AST_SAR_TIME: assert property ( // see RULE14
        @(posedge clk_sys) disable iff (reset)
        conv.start |-> ##14 conv.done)
        else $error("conversion did not finish 14 cycles after start");

    AST_SAR_CORR: assert property ( // see RULE8
        @(posedge clk_sys) disable iff (reset)
        conv.start |=> target_ff ==
            (($past(conv.sample) - $past(conv.corr)) ^ SIGN_FLIP))
        else $error("correction not applied to held sample");

    AST_SAR_EXACT: assert property ( // see RULE8
        @(posedge clk_sys) disable iff (reset)
        conv.done |-> approx_ff == target_ff)
        else $error("approximation did not converge to corrected sample");

endmodule : sas_sar_engine

// [tb_sas_acq_sequencer.sv]
// Self-checking bench of the acquisition sequencer
`timescale 1ns/100ps
module tb_sas_acq_sequencer
    import sas_pkg::*;
;
    localparam int TL = 40;
    typedef struct {int m; logic [12:0] code; logic [7:0] hi, lo;} sas_row_t;
    sas_row_t rows [4] = '{'{0, 13'h0105, 8'h01, 8'h00},
        '{1, 13'h1005, 8'hf0, 8'h00}, '{0, 13'h0004, 8'hff, 8'hff},
        '{2, 13'h0abc, 8'h00, 8'h00}};
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [CODE_W-1:0] analogCode = 13'h0005;
    logic [ADDR_W-1:0] regAddr = 8'h00;
    logic [DATA_W-1:0] regWrData = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic clr = 1'b0;
    wire logic [PIN_N-1:0] hostPins;
    wire logic hostTo;
    logic [7:0] busByte, b;
    logic busOe, convDone, acqOpen, irq;
    logic [DATA_W-1:0] regRdData, d;
    int fail_count = 0;
    int compares = 0;
    int lowCnt, acqCnt, nullCnt;
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end
    sas_acq_sequencer #(.TRIM_LEN(TL)) i_sas_acq_sequencer (
        .clk_sys(clk_sys), .reset(reset),
        .csN(hostPins[PIN_CS]), .wrN(hostPins[PIN_WR]),
        .rdN(hostPins[PIN_RD]), .shN(hostPins[PIN_SH]),
        .trimReqN(hostPins[PIN_TRIM]),
        .offset_null_request_n(hostPins[PIN_NULL]),
        .analogCode(analogCode), .result_byte_bus(busByte),
        .result_byte_bus_oe(busOe), .convDone(convDone),
        .acqOpen(acqOpen), .irq(irq), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData));
    sas_host_model i_sas_host_model (.clk_sys(clk_sys),
        .result_byte_bus(busByte), .result_byte_bus_oe(busOe),
        .pins(hostPins), .timedOut(hostTo));
    ////////////////////////////////////////////////////////////////////
    // Phase counters
    always @(posedge clk_sys)
    begin
        if (clr || reset)
        begin
            lowCnt <= 0;
            acqCnt <= 0;
            nullCnt <= 0;
        end
        else if (convDone === 1'b0)
        begin
            lowCnt <= lowCnt + 1;
            if (acqOpen === 1'b1)
                acqCnt <= acqCnt + 1;
            else if (acqCnt == 0)
                nullCnt <= nullCnt + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    task report_and_stop();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    task chkWord(input logic [31:0] got, exp, input string s);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: %s got %h exp %h", $time, s, got, exp);
        end
    endtask : chkWord
    task chkBit(input logic got, exp, input string s);
        chkWord({31'h0, got}, {31'h0, exp}, s);
    endtask : chkBit
    task regWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= v;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : regWrite
    task chkReg(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 d = regRdData;
        chkWord(d, e, "register read");
    endtask : chkReg
    task waitDone(input logic lvl, input int n);
        int i;
        for (i = 0; i < n && convDone !== lvl; i++)
            @(posedge clk_sys);
        if (i == n)
        begin
            fail_count++;
            $display("Error at %0t: wait ran out", $time);
            report_and_stop();
        end
    endtask : waitDone
    task clrCnt();
        @(posedge clk_sys);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
    endtask : clrCnt
    task trimCheck();
        waitDone(1'b1, TL + 40);
        chkBit(lowCnt inside {[TL - 1:TL + 3]}, 1'b1, "trim");
        chkReg(REG_CORR0, 32'h5);
        chkReg(REG_CORR1, 32'h5);
        chkReg(REG_CORR2, 32'h5);
    endtask : trimCheck
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        @(posedge clk_sys);
        #1;
        chkWord({convDone, acqOpen, busOe, irq}, 4'h0, "reset outputs");
        chkWord(regRdData, 32'h0, "reset read data");
        @(posedge clk_sys);
        reset <= 1'b0;
        trimCheck();
        chkReg(REG_STATUS, 32'h2);
        chkReg(REG_STATE, 32'h19);
        chkReg(8'h40, 32'h0);
        chkBit(irq, 1'b0, "masked irq");
        regWrite(REG_MASK, 32'h2);
        chkBit(irq, 1'b1, "irq raised");
        regWrite(REG_STATUS, 32'h2);
        chkBit(irq, 1'b0, "irq cleared");
        regWrite(REG_MASK, 32'h1);
        $display("test reset and trim done");
        foreach (rows[k])
        begin
            analogCode <= rows[k].code;
            clrCnt();
            i_sas_host_model.startConv(rows[k].m);
            waitDone(1'b0, 20);
            if (rows[k].m == 1)
                analogCode <= 13'h0aaa;
            waitDone(1'b1, 200);
            chkBit(acqOpen, 1'b1, "acq at done");
            chkWord(acqCnt, (rows[k].m == 2) ? ACQ_CYCLES : 0,
                "acq");
            if (rows[k].m == 2)
                chkWord(nullCnt, NULL_CYCLES, "null");
            i_sas_host_model.readByte(b);
            chkWord(b, rows[k].hi, "high byte");
            i_sas_host_model.readByte(b);
            chkWord(b, rows[k].lo, "low byte");
            i_sas_host_model.readByte(b);
            chkWord(b, rows[k].hi, "third read");
            $display("test row %0d done", k);
        end
        chkBit(hostTo, 1'b0, "read timeout");
        chkBit(irq, 1'b1, "conversion irq");
        chkReg(REG_STATUS, 32'h5);
        regWrite(REG_STATUS, 32'h7);
        chkBit(irq, 1'b0, "irq cleared");
        analogCode <= 13'h0005;
        clrCnt();
        i_sas_host_model.trim();
        i_sas_host_model.startConv(0);
        trimCheck();
        $display("test trim with refused start done");
        report_and_stop();
    end
endmodule : tb_sas_acq_sequencer
